// *** hw/sram_host_pkg.sv ***
// Purpose: Shared constants for the static RAM host controller.
// Assumes: 125 MHz system clock and the slower speed grade of the RAM.
// Notes: Times are in ns; cycle counts derive from them.
package sram_host_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  localparam int CLK_NS = 8;
  localparam int T_READ_CYCLE_NS = 70;
  localparam int T_ADDR_TO_DATA_NS = 70;
  localparam int T_OE_OFF_NS = 25;
  localparam int T_WE_PULSE_NS = 50;
  localparam int T_ADDR_TO_WEND_NS = 60;
  localparam int T_WRITE_CYCLE_NS = 70;
  localparam int WRITE_STROBE_OUTPUT_OFF_DELAY_NS = 25;
  localparam int WRITE_DATA_SETUP_TIME_NS = 30;
  localparam int SYNC_STAGES = 2;
  // Least times round up to whole cycles.
  localparam int WE_PULSE_CYC = (T_WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int AW_CYC = (T_ADDR_TO_WEND_NS + CLK_NS - 1) / CLK_NS;
  localparam int SD_CYC = (WRITE_DATA_SETUP_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int WMIN_CYC = (WRITE_STROBE_OUTPUT_OFF_DELAY_NS
    + WRITE_DATA_SETUP_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int WC_CYC = (T_WRITE_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_LOW_CYC = (WE_PULSE_CYC > AW_CYC - 1) ?
    WE_PULSE_CYC : AW_CYC - 1;
  localparam int RD_CYC = (T_ADDR_TO_DATA_NS + CLK_NS - 1) / CLK_NS
    + SYNC_STAGES;
  localparam int RC_CYC = (T_READ_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TURN_CYC = (T_OE_OFF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [CNT_W-1:0] WE_LOW_LOAD = CNT_W'(WE_LOW_CYC);
  localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(RD_CYC);
  localparam logic [CNT_W-1:0] TURN_LOAD = CNT_W'(TURN_CYC);
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
endpackage : sram_host_pkg

// *** hw/sram_phase_timer.sv ***
// Purpose: Down counter that times one phase of a RAM access.
// Assumes: A load value of at least one.
// Notes: o_last is high in the final cycle of a phase of i_value cycles.
`timescale 1ns/10ps
module sram_phase_timer
  import sram_host_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_load,
  input wire logic [CNT_W-1:0] i_value,
  output logic o_last
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (i_load)
    begin
      cnt_d = i_value;
    end
    else if (cnt_q != '0)
    begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  assign o_last = (cnt_q == CNT_W'(1));
endmodule : sram_phase_timer

// *** hw/sram_host_ctrl.sv ***
// Purpose: Host controller that reads and writes a 32K x 8 static RAM.
// Assumes: One request at a time; i_req is taken only while o_ready.
// Notes: Writes are write-strobe controlled with output enable held high.
// Contract
// - Data setup and hold against ending edge.
// - Write cycle covers turn-off plus data setup.
// - Address valid no later than select falling.
// - Never drive pins while device drives them.
`timescale 1ns/10ps
module sram_host_ctrl
  import sram_host_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  output logic o_ready,
  output logic o_rvalid,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic [ADDR_W-1:0] o_address_pins,
  output logic [DATA_W-1:0] o_data_pins,
  output logic o_data_pins_oe,
  input wire logic [DATA_W-1:0] i_data_pins
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_WSET = 6'b00_0010,
    ST_WLOW = 6'b00_0100,
    ST_WEND = 6'b00_1000,
    ST_READ = 6'b01_0000,
    ST_TURN = 6'b10_0000
  } state_e;

  state_e state_q;
  state_e state_d;
  logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
  logic dout_oe_q, dout_oe_d, rvalid_q, rvalid_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] dout_q, dout_d, rdata_q, rdata_d;
  logic [DATA_W-1:0] din_meta_q, din_sync_q;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_value;
  logic tmr_last;

  sram_phase_timer u_timer (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(tmr_load),
    .i_value(tmr_value),
    .o_last(tmr_last)
  );

  // The data pins come from another chip, so they pass two flops.
  always_ff @(posedge i_sys_clk)
  begin
    din_meta_q <= i_data_pins;
    din_sync_q <= din_meta_q;
  end

  always_comb
  begin
    state_d = state_q;
    ce_n_d = ce_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    dout_oe_d = dout_oe_q;
    addr_d = addr_q;
    dout_d = dout_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    tmr_load = 1'b0;
    tmr_value = WE_LOW_LOAD;
    case (state_q)
      ST_IDLE:
      begin
        if (i_req)
        begin
          // Address and select change on the same edge.
          addr_d = i_addr;
          ce_n_d = 1'b0;
          if (i_write)
          begin
            dout_d = i_wdata;
            state_d = ST_WSET;
          end
          else
          begin
            oe_n_d = 1'b0;
            tmr_load = 1'b1;
            tmr_value = RD_LOAD;
            state_d = ST_READ;
          end
        end
      end
      ST_WSET:
      begin
        // Output enable stays high, so the RAM never drives here.
        we_n_d = 1'b0;
        dout_oe_d = 1'b1;
        tmr_load = 1'b1;
        // The low time also covers turn-off plus data setup.
        tmr_value = WE_LOW_LOAD;
        state_d = ST_WLOW;
      end
      ST_WLOW:
      begin
        if (tmr_last)
        begin
          // Both strobes rise together and data holds one cycle.
          we_n_d = 1'b1;
          ce_n_d = 1'b1;
          state_d = ST_WEND;
        end
      end
      ST_WEND:
      begin
        dout_oe_d = 1'b0;
        state_d = ST_IDLE;
      end
      ST_READ:
      begin
        if (tmr_last)
        begin
          rdata_d = din_sync_q;
          rvalid_d = 1'b1;
          ce_n_d = 1'b1;
          oe_n_d = 1'b1;
          tmr_load = 1'b1;
          tmr_value = TURN_LOAD;
          state_d = ST_TURN;
        end
      end
      ST_TURN:
      begin
        // Wait out the RAM's output turn-off before the bus may flip.
        if (tmr_last)
        begin
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      state_q <= ST_IDLE;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      dout_oe_q <= 1'b0;
      rvalid_q <= 1'b0;
      addr_q <= ADDR_RST;
      dout_q <= DATA_RST;
      rdata_q <= DATA_RST;
    end
    else
    begin
      state_q <= state_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      dout_oe_q <= dout_oe_d;
      rvalid_q <= rvalid_d;
      addr_q <= addr_d;
      dout_q <= dout_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_ready = (state_q == ST_IDLE);
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_ce_n = ce_n_q;
  assign o_oe_n = oe_n_q;
  assign o_we_n = we_n_q;
  assign o_address_pins = addr_q;
  assign o_data_pins = dout_q;
  assign o_data_pins_oe = dout_oe_q;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  property p_data_setup_hold;
    $fell(o_we_n) |-> (o_data_pins_oe && $stable(o_data_pins))[*7]
      ##1 (o_we_n && o_ce_n && o_data_pins_oe && $stable(o_data_pins));
  endproperty
  a_data_setup_hold: assert property (p_data_setup_hold)
    else $error("Write data not held around the ending strobe edge.");

  property p_write_cycle_len;
    $fell(o_we_n) |-> ($past(o_ce_n) == 1'b0) ##0 (!o_ce_n)[*7] ##1 o_ce_n;
  endproperty
  a_write_cycle_len: assert property (p_write_cycle_len)
    else $error("Write cycle shorter than turn-off plus setup.");

  property p_addr_stable;
    (!o_ce_n && !$past(o_ce_n)) |-> $stable(o_address_pins);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("Address moved while the RAM was selected.");

  property p_no_contention;
    o_data_pins_oe |-> o_oe_n;
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("Host drives data while RAM outputs are enabled.");

  property p_read_timing;
    $fell(o_oe_n) |-> (!o_oe_n && !o_ce_n && o_we_n)[*8]
      ##1 (!o_oe_n && !o_ce_n && o_we_n)[*3]
      ##1 (o_rvalid && o_oe_n && o_ce_n);
  endproperty
  a_read_timing: assert property (p_read_timing)
    else $error("Read did not last its access time.");

  property p_turnaround;
    o_rvalid |-> (!o_ready)[*4] ##1 o_ready;
  endproperty
  a_turnaround: assert property (p_turnaround)
    else $error("Bus turnaround after a read is wrong.");

  c_write: cover property ($fell(o_we_n) ##[1:20] $rose(o_we_n));
  c_read: cover property (o_rvalid);
  c_back_to_back: cover property (o_rvalid ##[1:20] $fell(o_we_n));
endmodule : sram_host_ctrl

// *** tb/sram_device_model.sv ***
// Purpose: Behavioural 32K x 8 static RAM seen from its pins.
// Assumes: Strobes are active low; the write is level sensitive.
// Notes: Read data lags the address by ACC_NS, so early samples are stale.
`timescale 1ns/10ps
module sram_device_model
  import sram_host_pkg::*;
#(
  parameter int ACC_NS = 60
)
(
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [ADDR_W-1:0] i_address_pins,
  input wire logic [DATA_W-1:0] i_data_pins,
  input wire logic i_host_oe,
  output logic [DATA_W-1:0] o_data_pins,
  output logic o_drive,
  output logic o_clash
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  always @*
  begin
    if (i_ce_n === 1'b0 && i_we_n === 1'b0)
    begin
      mem[i_address_pins] = i_data_pins;
    end
  end
  // Drivers open only for the full read combination, never otherwise.
  assign o_drive = !i_ce_n && !i_oe_n && i_we_n;
  assign #(ACC_NS) o_data_pins = mem[i_address_pins];
  assign o_clash = o_drive && i_host_oe;
endmodule : sram_device_model

// *** tb/test_sram_host_ctrl.sv ***
// Purpose: Self-checking bench for the static RAM host controller.
// Assumes: The device model answers reads after the full access time.
// Notes: A floating data bus shows a value that changes every cycle.
`timescale 1ns/10ps
module test_sram_host_ctrl
  import sram_host_pkg::*;
;
  logic sys_clk, rst, req, wr, ready, rvalid, ce_n, oe_n, we_n;
  logic hoe, ram_oe, clash;
  logic [ADDR_W-1:0] addr, apins;
  logic [DATA_W-1:0] wdata, rdata, hdata, ram_q, bus, bus_hold;
  int n_fail, checks_done, cycles;
  sram_host_ctrl dut (.i_sys_clk(sys_clk), .i_sys_rst(rst), .i_req(req),
    .i_write(wr), .i_addr(addr), .i_wdata(wdata), .o_ready(ready),
    .o_rvalid(rvalid), .o_rdata(rdata), .o_ce_n(ce_n), .o_oe_n(oe_n),
    .o_we_n(we_n), .o_address_pins(apins), .o_data_pins(hdata),
    .o_data_pins_oe(hoe), .i_data_pins(bus));
  sram_device_model #(.ACC_NS(T_ADDR_TO_DATA_NS)) ram (.i_ce_n(ce_n),
    .i_oe_n(oe_n),
    .i_we_n(we_n), .i_address_pins(apins), .i_data_pins(bus),
    .i_host_oe(hoe), .o_data_pins(ram_q), .o_drive(ram_oe),
    .o_clash(clash));
  assign bus = hoe ? hdata : (ram_oe ? ram_q : ~bus_hold);
  always @(posedge sys_clk) bus_hold <= bus;
  always #4 sys_clk = ~sys_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  // A poke raises a request mid-transfer that must be ignored.
  task automatic send(input logic w, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, input logic poke, output int lat);
    @(posedge sys_clk);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    req <= 1'b0;
    lat = 0;
    do
    begin
      @(posedge sys_clk);
      lat++;
      req <= poke && lat == 3;
      addr <= ~a;
      wdata <= ~d;
      #1;
    end
    while (!(w ? ready === 1'b1 : rvalid === 1'b1) && lat < 40);
    while (ready !== 1'b1)
    begin
      @(posedge sys_clk);
      #1;
    end
  endtask : send
  task automatic wr_chk(input logic [14:0] a, input logic [7:0] d,
    input logic poke);
    int lat;
    send(1'b1, a, d, poke, lat);
    check(16'(lat), 16'(WE_LOW_CYC + 2));
  endtask : wr_chk
  task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
    int lat;
    send(1'b0, a, 8'h00, 1'b0, lat);
    check(16'(lat), 16'(RD_CYC));
    check({8'h00, rdata}, {8'h00, e});
  endtask : rd_chk
  task automatic boundary_rw();
    wr_chk(15'h0000, 8'hA5, 1'b0);
    wr_chk(15'h7FFF, 8'h5A, 1'b0);
    rd_chk(15'h0000, 8'hA5);
    rd_chk(15'h7FFF, 8'h5A);
  endtask : boundary_rw
  task automatic overwrite_b2b();
    wr_chk(15'h1234, 8'h11, 1'b0);
    wr_chk(15'h1234, 8'h22, 1'b0);
    rd_chk(15'h1234, 8'h22);
    rd_chk(15'h1234, 8'h22);
  endtask : overwrite_b2b
  task automatic refused_req();
    wr_chk(15'h70F0, 8'h81, 1'b0);
    wr_chk(15'h0F0F, 8'h3C, 1'b1);
    rd_chk(15'h70F0, 8'h81);
    rd_chk(15'h0F0F, 8'h3C);
  endtask : refused_req
  // A reset, also mid-run, must bring every pin back to idle.
  task automatic reset_state(input logic pulse);
    if (pulse)
    begin
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
    end
    @(posedge sys_clk);
    #1;
    check({10'h000, ce_n, oe_n, we_n, hoe, ready, rvalid}, 16'h003A);
    check({1'b0, apins}, {1'b0, ADDR_RST});
    check({8'h00, rdata}, {8'h00, DATA_RST});
  endtask : reset_state
  always @(posedge sys_clk)
  begin
    cycles++;
    if (!rst && clash !== 1'b0)
      check(16'h0001, 16'h0000);
    if (cycles == 2000)
    begin
      n_fail++;
      final_report();
    end
  end
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    req = 1'b0;
    wr = 1'b0;
    addr = 15'h0000;
    wdata = 8'h00;
    bus_hold = 8'h00;
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    reset_state(1'b0);
    boundary_rw();
    overwrite_b2b();
    reset_state(1'b1);
    refused_req();
    final_report();
  end
endmodule : test_sram_host_ctrl
